// file: src/ujh_pkg.sv
// Summary of operation
// (R1) CRC-off bit set skips CRC, clear computes.
// (R2) Issuer sets last-header flag in final header.
// (R3) Count zero, null base: use embedded header words.
// (R4) Issuer writes reserved header bits as zero.
// (R5) Block bits outside 40..5114 are reserved.
// (R6) Collection type: separate, or 2/4/6-row interleaver.
// (R7) Collection-select zero interlaces all three streams.
// (R8) Channel count only for interleaver; zero reserved.
// (R9) Stage two punctures on zero, repeats on one.
// (R10) Restart bit reloads errors, else keeps state.
// (R11) Input fetch starts at input bit offset.
// (R12) First encoded bit goes at output offset.
// (R13) Chained bit marks block as transport-block follower.
// (R14) Parity offsets apply when collection-select is set.
// (R15) Code-block count yields the internal X parameter.
// (R16) Systematic error fields widened by two bits.
// (R17) Parity fields widened by three or two bits.
// (R18) Issuer zeroes stage-one decrement for enhanced channel.
// (R19) Issuer sets stage-one initials above zero there.
// (R20) Each parity stream has own stage-two values.
// (R21) Descriptor carries up to eight header words.
// (R22) Subtract decrement per bit; select at zero.
`default_nettype none

package ujh_pkg;

	// ------------------------------------------------------------
	// Register map, byte addresses on the register bus.
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_JOB    = 8'h04;
	localparam logic [7:0] ADDR_HBASE  = 8'h08;
	localparam logic [7:0] ADDR_INPTR  = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_EPLUS  = 8'h14;
	localparam logic [7:0] ADDR_RMERR  = 8'h18;
	// Header word memory sits at 0x40..0x7C: slots 0-7 embedded.
	localparam logic [1:0] MEM_REGION  = 2'h1;
	localparam int         CTRL_START  = 0;

	// ------------------------------------------------------------
	// Reset values, limits and counts.
	// ------------------------------------------------------------
	localparam logic [31:0] RST_WORD  = 32'h0000_0000;
	localparam logic [15:0] RST_EPLUS = 16'h0000;
	localparam logic [12:0] CBS_MIN   = 13'h0028;
	localparam logic [12:0] CBS_MAX   = 13'h13FA;
	localparam logic [3:0]  HDR_WORDS = 4'h8;

	typedef enum {SEQ_IDLE, SEQ_FETCH, SEQ_LOAD} ujh_seq_t;

	// ------------------------------------------------------------
	// Header word layouts.
	// ------------------------------------------------------------
	typedef struct packed {
		logic [2:0]  rsv;
		logic [3:0]  phys_ch;
		logic [2:0]  hdr_count;
		logic        crc_off;
		logic        last_header_flag;
		logic        scrambler_off;
		logic        rm_restart;
		logic        repeat_sel;
		logic        chained;
		logic        coll_sel;
		logic [1:0]  coll_type;
		logic [12:0] block_bits;
	} ujh_w0_t;

	typedef struct packed {
		logic [15:0] hi;
		logic [15:0] lo;
	} ujh_half_t;

	// One word carrying two error fields with their extensions.
	typedef struct packed {
		logic        rsv;
		logic [1:0]  hi_ext;
		logic [12:0] hi;
		logic [2:0]  lo_ext;
		logic [12:0] lo;
	} ujh_epair_t;

	typedef struct packed {
		logic [7:0]  rsv;
		logic [7:0]  ncb;
		logic [2:0]  rsv2;
		logic [12:0] first_parity_stage2_decrement;
	} ujh_w7_t;

	typedef struct packed {
		logic        rsv;
		logic        embedded;
		logic        last_err;
		logic        phys_err;
		logic        size_err;
		logic        cfg_valid;
		logic        busy;
	} ujh_status_t;

	// Decoded configuration handed to the encoder engine.
	typedef struct packed {
		logic        crc_en;
		logic        scram_en;
		logic        interlace;
		logic [2:0]  rows;
		logic [3:0]  phys_ch;
		logic        repeat_en;
		logic        chained;
		logic        par_off_en;
		logic [31:0] in_ptr;
		logic [15:0] in_bit_off;
		logic [15:0] out_bit_off;
		logic [15:0] pfo;
		logic [15:0] pso;
		logic [7:0]  x_param;
		logic [15:0] sys_eini;
		logic [15:0] sys_eminus;
		logic [15:0] p1_eini1;
		logic [15:0] p2_eini1;
		logic [15:0] p1_eini2;
		logic [15:0] p2_eini2;
		logic [15:0] p_eminus1;
		logic [15:0] p1_eminus2;
		logic [15:0] p2_eminus2;
	} ujh_cfg_t;

	// Widens a base error field by its extension bits.
	function automatic logic [15:0] widen(
		input logic [12:0] base,
		input logic [2:0]  ext
	);
		return {ext, base};
	endfunction : widen

	// Merges bus write data into a register under byte enables.
	function automatic logic [31:0] be_merge(
		input logic [31:0] old,
		input logic [31:0] wdata,
		input logic [3:0]  be
	);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[i*8 +: 8] = wdata[i*8 +: 8];
		return r;
	endfunction : be_merge

endpackage : ujh_pkg

`default_nettype wire

// file: src/ujh_hdr_mem.sv
`default_nettype none

// ----------------------------------------------------------------
// Header word store: sixteen words, byte writes, registered read.
// ----------------------------------------------------------------
module ujh_hdr_mem (
	// Clock.
	input  wire logic        mclk,
	// Write port.
	input  wire logic        we,
	input  wire logic [3:0]  waddr,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wbe,
	// Read port.
	input  wire logic [3:0]  raddr,
	output var  logic [31:0] rdata
);

	logic [31:0] mem_r [16];

	// Write under byte enables; read data come out one edge later.
	always_ff @(posedge mclk)
	begin
		if (we)
			mem_r[waddr] <= ujh_pkg::be_merge(mem_r[waddr], wdata, wbe);
		rdata <= mem_r[raddr];
	end

endmodule : ujh_hdr_mem

`default_nettype wire

// file: src/ujh_decode.sv
// Added by the designer: the register offsets and the Avalon-MM slave port.
`default_nettype none

// ----------------------------------------------------------------
// Job header decoder with register bus and error-variable engine.
// ----------------------------------------------------------------
module ujh_decode (
	// Clock and reset.
	input  wire logic             mclk,
	input  wire logic             rst,
	// Register bus.
	input  wire logic [7:0]       avs_address,
	input  wire logic             avs_read,
	input  wire logic             avs_write,
	input  wire logic [31:0]      avs_writedata,
	input  wire logic [3:0]       avs_byteenable,
	output var  logic [31:0]      avs_readdata,
	output var  logic             avs_waitrequest,
	// Engine side.
	output var  ujh_pkg::ujh_cfg_t cfg,
	output var  logic             cfg_valid,
	input  wire logic             rm_step,
	output var  logic             rm_sel
);

	// ------------------------------------------------------------
	// State.
	// ------------------------------------------------------------
	ujh_pkg::ujh_seq_t  seq_r;
	logic [3:0]         idx_r;
	logic               bank_r;
	logic [31:0]        hw_r [8];
	logic               phase_r;
	logic [3:0]         job_count_r;
	logic [31:0]        hbase_r;
	logic [31:0]        inptr_r;
	logic [15:0]        eplus_r;
	logic signed [19:0] e_r;
	logic               size_err_r;
	logic               phys_err_r;
	logic               last_err_r;
	logic [31:0]        mem_rdata;

	// ------------------------------------------------------------
	// Bus decode.
	// ------------------------------------------------------------
	wire        req       = avs_read | avs_write;
	wire        ack       = req & ~avs_waitrequest;
	wire        busy      = (seq_r != ujh_pkg::SEQ_IDLE);
	wire        sel_mem   = (avs_address[7:6] == ujh_pkg::MEM_REGION);
	wire        wr_ack    = ack & avs_write;
	wire        wr_ctrl   = wr_ack & (avs_address == ujh_pkg::ADDR_CTRL);
	wire        start     = wr_ctrl & avs_byteenable[0]
				& avs_writedata[ujh_pkg::CTRL_START];
	wire [31:0] wmerge_j  = ujh_pkg::be_merge({28'h000_0000, job_count_r},
				avs_writedata, avs_byteenable);
	wire [31:0] wmerge_h  = ujh_pkg::be_merge(hbase_r, avs_writedata,
				avs_byteenable);
	wire [31:0] wmerge_i  = ujh_pkg::be_merge(inptr_r, avs_writedata,
				avs_byteenable);
	wire [31:0] wmerge_e  = ujh_pkg::be_merge({16'h0000, eplus_r},
				avs_writedata, avs_byteenable);
	// Header words are taken from the descriptor itself only when no
	// separate header area is named.
	wire        embedded  = (job_count_r == 4'h0)
				& (hbase_r == ujh_pkg::RST_WORD); // R3

	ujh_pkg::ujh_status_t st;
	assign st = '{rsv: 1'b0, embedded: ~bank_r, last_err: last_err_r,
		phys_err: phys_err_r, size_err: size_err_r,
		cfg_valid: cfg_valid, busy: busy};

	wire [31:0] rd_mux =
		sel_mem ? mem_rdata :
		(avs_address == ujh_pkg::ADDR_JOB)    ? {28'h000_0000, job_count_r} :
		(avs_address == ujh_pkg::ADDR_HBASE)  ? hbase_r :
		(avs_address == ujh_pkg::ADDR_INPTR)  ? inptr_r :
		(avs_address == ujh_pkg::ADDR_STATUS) ? {25'h000_0000, st} :
		(avs_address == ujh_pkg::ADDR_EPLUS)  ? {16'h0000, eplus_r} :
		(avs_address == ujh_pkg::ADDR_RMERR)  ? {{12{e_r[19]}}, e_r} :
		ujh_pkg::RST_WORD;

	// ------------------------------------------------------------
	// Header word store; the sequencer owns the read port when busy.
	// ------------------------------------------------------------
	wire [3:0] mem_raddr = busy ? {bank_r, idx_r[2:0]}
				: avs_address[5:2];

	ujh_hdr_mem u_mem (
		.mclk  (mclk),
		.we    (wr_ack & sel_mem),
		.waddr (avs_address[5:2]),
		.wdata (avs_writedata),
		.wbe   (avs_byteenable),
		.raddr (mem_raddr),
		.rdata (mem_rdata)
	);

	// ------------------------------------------------------------
	// Bus handshake: request seen, data fetched, one low wait cycle.
	// A request that arrives while a header fetch runs is held off.
	// ------------------------------------------------------------
	wire phase_nxt = req & avs_waitrequest & ~phase_r & ~busy;

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			phase_r         <= 1'b0;
			avs_waitrequest <= 1'b1;
			avs_readdata    <= ujh_pkg::RST_WORD;
		end
		else
		begin
			phase_r         <= phase_nxt;
			avs_waitrequest <= ~phase_r;
			if (phase_r)
				avs_readdata <= rd_mux;
		end
	end

	// Software registers; writes land on the acknowledging edge.
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			job_count_r <= 4'h0;
			hbase_r     <= ujh_pkg::RST_WORD;
			inptr_r     <= ujh_pkg::RST_WORD;
			eplus_r     <= ujh_pkg::RST_EPLUS;
		end
		else if (wr_ack)
		begin
			if (avs_address == ujh_pkg::ADDR_JOB)
				job_count_r <= wmerge_j[3:0];
			if (avs_address == ujh_pkg::ADDR_HBASE)
				hbase_r <= wmerge_h;
			if (avs_address == ujh_pkg::ADDR_INPTR)
				inptr_r <= wmerge_i;
			if (avs_address == ujh_pkg::ADDR_EPLUS)
				eplus_r <= wmerge_e[15:0];
		end
	end

	// ------------------------------------------------------------
	// Fetch sequencer: reads all eight header words, then loads.
	// ------------------------------------------------------------
	wire [2:0] cap_idx = 3'(idx_r - 4'h1);

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			seq_r  <= ujh_pkg::SEQ_IDLE;
			idx_r  <= 4'h0;
			bank_r <= 1'b0;
		end
		else
		begin
			unique case (seq_r)
				ujh_pkg::SEQ_IDLE:
					if (start)
					begin
						seq_r  <= ujh_pkg::SEQ_FETCH;
						idx_r  <= 4'h0;
						bank_r <= ~embedded; // R3
					end
				ujh_pkg::SEQ_FETCH:
				begin
					idx_r <= idx_r + 4'h1;
					if (idx_r == ujh_pkg::HDR_WORDS) // R21
						seq_r <= ujh_pkg::SEQ_LOAD;
				end
				ujh_pkg::SEQ_LOAD:
					seq_r <= ujh_pkg::SEQ_IDLE;
			endcase
		end
	end

	// Captured words trail the read address by one edge.
	always_ff @(posedge mclk)
	begin
		if (seq_r == ujh_pkg::SEQ_FETCH && idx_r != 4'h0)
			hw_r[cap_idx] <= mem_rdata;
	end

	// ------------------------------------------------------------
	// Field decode of the captured header words.
	// ------------------------------------------------------------
	ujh_pkg::ujh_w0_t    w0;
	ujh_pkg::ujh_half_t  w1;
	ujh_pkg::ujh_half_t  w2;
	ujh_pkg::ujh_epair_t w3;
	ujh_pkg::ujh_epair_t w4;
	ujh_pkg::ujh_epair_t w5;
	ujh_pkg::ujh_epair_t w6;
	ujh_pkg::ujh_w7_t    w7;
	ujh_pkg::ujh_cfg_t   cfg_nxt;

	assign w0 = hw_r[0];
	assign w1 = hw_r[1];
	assign w2 = hw_r[2];
	assign w3 = hw_r[3];
	assign w4 = hw_r[4];
	assign w5 = hw_r[5];
	assign w6 = hw_r[6];
	assign w7 = hw_r[7];

	wire size_ok = (w0.block_bits >= ujh_pkg::CBS_MIN)
		& (w0.block_bits <= ujh_pkg::CBS_MAX); // R5
	wire rect    = w0.coll_sel & (w0.coll_type != 2'h0);

	// Reserved fields are never interpreted, only ignored.
	assign cfg_nxt.crc_en      = ~w0.crc_off; // R1
	assign cfg_nxt.scram_en    = ~w0.scrambler_off;
	assign cfg_nxt.interlace   = ~w0.coll_sel; // R7
	assign cfg_nxt.rows        = rect ? {w0.coll_type, 1'b0} : 3'h0; // R6
	assign cfg_nxt.phys_ch     = rect ? w0.phys_ch : 4'h0; // R8
	assign cfg_nxt.repeat_en   = w0.repeat_sel; // R9
	assign cfg_nxt.chained     = w0.chained; // R13
	assign cfg_nxt.par_off_en  = w0.coll_sel; // R14
	assign cfg_nxt.in_ptr      = inptr_r; // R11
	assign cfg_nxt.in_bit_off  = w1.lo; // R11
	assign cfg_nxt.out_bit_off = w1.hi; // R12
	assign cfg_nxt.pfo         = w2.lo; // R14
	assign cfg_nxt.pso         = w2.hi; // R14
	assign cfg_nxt.x_param     = w7.ncb; // R15
	assign cfg_nxt.sys_eini    = ujh_pkg::widen(w3.lo,
		{1'b0, w3.lo_ext[1:0]}); // R16
	assign cfg_nxt.sys_eminus  = ujh_pkg::widen(w3.hi, {1'b0, w3.hi_ext});
	assign cfg_nxt.p1_eini1    = ujh_pkg::widen(w4.lo, w4.lo_ext); // R17
	assign cfg_nxt.p2_eini1    = ujh_pkg::widen(w4.hi, {1'b0, w4.hi_ext});
	assign cfg_nxt.p1_eini2    = ujh_pkg::widen(w5.lo, w5.lo_ext); // R20
	assign cfg_nxt.p2_eini2    = ujh_pkg::widen(w5.hi, {1'b0, w5.hi_ext});
	assign cfg_nxt.p_eminus1   = ujh_pkg::widen(w6.lo, w6.lo_ext); // R17
	assign cfg_nxt.p2_eminus2  = ujh_pkg::widen(w6.hi, {1'b0, w6.hi_ext});
	assign cfg_nxt.p1_eminus2  = ujh_pkg::widen(
		w7.first_parity_stage2_decrement, 3'h0); // R20

	// Load the decoded set; an out-of-range size leaves it invalid.
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			cfg        <= '0;
			cfg_valid  <= 1'b0;
			size_err_r <= 1'b0;
			phys_err_r <= 1'b0;
			last_err_r <= 1'b0;
		end
		else if (start)
			cfg_valid <= 1'b0;
		else if (seq_r == ujh_pkg::SEQ_LOAD)
		begin
			cfg        <= cfg_nxt;
			cfg_valid  <= size_ok; // R5
			size_err_r <= ~size_ok;
			phys_err_r <= rect & (w0.phys_ch == 4'h0); // R8
			last_err_r <= ~w0.last_header_flag;
		end
	end

	// ------------------------------------------------------------
	// Systematic error variable: reloaded or carried across blocks.
	// ------------------------------------------------------------
	wire signed [19:0] e_dec = e_r - $signed({4'h0, cfg.sys_eminus});
	wire               hit   = (e_dec <= 20'sh0_0000); // R22

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			e_r    <= 20'sh0_0000;
			rm_sel <= 1'b0;
		end
		else
		begin
			rm_sel <= rm_step & cfg_valid & hit; // R22
			if (seq_r == ujh_pkg::SEQ_LOAD && w0.rm_restart) // R10
				e_r <= $signed({4'h0, cfg_nxt.sys_eini});
			else if (rm_step && cfg_valid)
				e_r <= hit ? e_dec + $signed({4'h0, eplus_r}) : e_dec;
		end
	end

	// ------------------------------------------------------------
	// Checks.
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	wire in_load = (seq_r == ujh_pkg::SEQ_LOAD);

	AST_CRC_POLARITY: assert property ( // R1
		in_load |=> cfg.crc_en == !$past(w0.crc_off))
		else $error("crc enable does not follow crc_off");
	AST_EMBEDDED_BANK: assert property ( // R3
		start |=> bank_r == !($past(embedded)))
		else $error("wrong header bank chosen");
	AST_SIZE_RANGE: assert property ( // R5
		in_load |=> cfg_valid == $past(size_ok))
		else $error("size range check wrong");
	AST_SIX_ROWS: assert property ( // R6
		in_load && w0.coll_sel && w0.coll_type == 2'h3
		|=> cfg.rows == 3'h6)
		else $error("interleaver rows wrong");
	AST_INTERLACE: assert property ( // R7
		in_load && !w0.coll_sel |=> cfg.interlace && cfg.rows == 3'h0
		&& !cfg.par_off_en)
		else $error("interlace mode wrong");
	AST_PHYS_IGNORED: assert property ( // R8
		in_load && !rect |=> cfg.phys_ch == 4'h0)
		else $error("channel count not ignored");
	AST_REPEAT: assert property ( // R9
		in_load |=> cfg.repeat_en == $past(w0.repeat_sel))
		else $error("repeat mode wrong");
	AST_RM_RELOAD: assert property ( // R10
		in_load && w0.rm_restart
		|=> e_r == $signed({4'h0, $past(cfg_nxt.sys_eini)}))
		else $error("error variable not reloaded");
	AST_OFFSETS: assert property ( // R12
		in_load |=> cfg.out_bit_off == $past(w1.hi)
		&& cfg.in_bit_off == $past(w1.lo))
		else $error("bit offsets wrong");
	AST_FETCH_LEN: assert property ( // R21
		start |-> ##10 in_load)
		else $error("header fetch length wrong");
	AST_RM_SELECT: assert property ( // R22
		rm_step && cfg_valid && hit |=> rm_sel ##1 !rm_sel || $past(rm_step))
		else $error("rate matching select missed");
	AST_WAIT_PULSE: assert property (
		!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");

	CVR_START: cover property (start ##10 in_load ##1 cfg_valid);
	CVR_HEADER_AREA: cover property (start && !embedded);
	CVR_RM_HIT: cover property (rm_sel);
	CVR_BAD_SIZE: cover property (in_load && !size_ok);

endmodule : ujh_decode

`default_nettype wire

// file: tb/ujh_job_ctrl.sv
`default_nettype none

// ----------------------------------------------------------------
// Job controller model: one register bus cycle at a time.
// ----------------------------------------------------------------
module ujh_job_ctrl (
	// Clock.
	input  wire logic        mclk,
	// Bus answer.
	input  wire logic [31:0] avs_readdata,
	input  wire logic        avs_waitrequest,
	// Bus request.
	output var  logic [7:0]  avs_address,
	output var  logic        avs_read,
	output var  logic        avs_write,
	output var  logic [31:0] avs_writedata,
	output var  logic [3:0]  avs_byteenable
);
	timeunit 1ns;
	timeprecision 1ns;

	// The bus is idle at time zero, all lanes enabled.
	initial
	begin
		avs_address    = 8'h00;
		avs_read       = 1'b0;
		avs_write      = 1'b0;
		avs_writedata  = 32'h0000_0000;
		avs_byteenable = 4'hf;
	end

	// Hold the request until waitrequest is sampled low, then release.
	// Write data is inverted on release so stale data is never reused.
	task automatic access(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge mclk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_read      <= !wr;
		avs_write     <= wr;
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0)
			@(posedge mclk);
		q = avs_readdata;
		avs_read      <= 1'b0;
		avs_write     <= 1'b0;
		avs_writedata <= ~d;
	endtask : access

endmodule : ujh_job_ctrl

`default_nettype wire

// file: tb/umts_encoder_job_header_decode_tb.sv
`default_nettype none

module umts_encoder_job_header_decode_tb;
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------------------------------
	// Signals.
	// ----------------------------------------------------------------
	logic              mclk;
	logic              rst;
	logic              rm_step;
	logic [7:0]        avs_address;
	logic              avs_read;
	logic              avs_write;
	logic [31:0]       avs_writedata;
	logic [3:0]        avs_byteenable;
	logic [31:0]       avs_readdata;
	logic              avs_waitrequest;
	ujh_pkg::ujh_cfg_t cfg;
	logic              cfg_valid;
	logic              rm_sel;
	logic [31:0]       hw [8];
	ujh_pkg::ujh_w0_t  h;
	logic [31:0]       q;
	int                err_total = 0;
	int                comparisons = 0;
	int                cycles = 0;

	// ----------------------------------------------------------------
	// Instances, clock and hang guard.
	// ----------------------------------------------------------------
	ujh_decode i_dut (.mclk(mclk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.cfg(cfg), .cfg_valid(cfg_valid), .rm_step(rm_step),
		.rm_sel(rm_sel));

	ujh_job_ctrl i_ctl (.mclk(mclk), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable));

	// A 100 ns clock.
	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// The whole run needs about five hundred cycles; far more means a hang.
	always @(posedge mclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			err_total = err_total + 1;
			final_report();
		end
	end

	// ----------------------------------------------------------------
	// Shared tasks.
	// ----------------------------------------------------------------
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		comparisons = comparisons + 1;
		if (g !== e)
		begin
			err_total = err_total + 1;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		i_ctl.access(1'b1, a, d, x);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] x);
		i_ctl.access(1'b0, a, 32'h0000_0000, x);
	endtask : rd

	task automatic put_words(input logic [7:0] base);
		for (int i = 0; i < 8; i++)
			wr(base + 8'(4 * i), hw[i]);
	endtask : put_words

	// The decoded set lands ten edges after the start is acknowledged.
	// Each check reads what stood just before the edge it waits on.
	task automatic run_job(input logic ok);
		wr(ujh_pkg::ADDR_CTRL, 32'h0000_0001);
		repeat (10) @(posedge mclk);
		chk("cfg_valid", 32'h0000_0000, 32'(cfg_valid));
		@(posedge mclk);
		chk("cfg_valid", 32'(ok), 32'(cfg_valid));
	endtask : run_job

	// Back-to-back steps; each selection shows one edge later.
	task automatic steps(input int n, input logic [3:0] sel);
		rm_step <= 1'b1;
		for (int i = 0; i < n; i++)
		begin
			@(posedge mclk);
			if (i == n - 1)
				rm_step <= 1'b0;
			@(negedge mclk);
			chk("rm_sel", 32'(sel[i]), 32'(rm_sel));
		end
	endtask : steps

	task automatic final_report;
		if (err_total == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : final_report

	// ----------------------------------------------------------------
	// Scenarios.
	// ----------------------------------------------------------------
	task automatic t_reset;
		chk("cfg", 32'h0000_0000, 32'(|cfg));
		chk("rm_sel", 32'h0000_0000, 32'(rm_sel));
		rd(ujh_pkg::ADDR_EPLUS, q);
		chk("eplus", 32'h0000_0000, q);
		wr(8'h20, 32'hFFFF_FFFF);
		rd(8'h20, q);
		chk("unmapped", 32'h0000_0000, q);
	endtask : t_reset

	// Embedded words must win over a filled header area when count and base are zero.
	task automatic t_fields;
		h = '0;
		h.block_bits = 13'h0064;
		h.coll_type = 2'b10;
		h.coll_sel = 1'b1;
		h.chained = 1'b1;
		h.repeat_sel = 1'b1;
		h.crc_off = 1'b1;
		h.scrambler_off = 1'b1;
		h.last_header_flag = 1'b1;
		h.phys_ch = 4'h3;
		hw = '{h, 32'h0123_0045, 32'h0200_0100, 32'h6002_4005,
			32'h3456_E789, 32'h2ABC_5DEF, 32'h1357_9BDF, 32'h0003_1ABC};
		wr(ujh_pkg::ADDR_JOB, 32'h0000_0000);
		wr(ujh_pkg::ADDR_HBASE, 32'h0000_0000);
		wr(ujh_pkg::ADDR_INPTR, 32'h8000_1234);
		put_words(8'h40);
		hw[1] = 32'h0BAD_0ACE;
		put_words(8'h60);
		hw[1] = 32'h0123_0045;
		run_job(1'b1);
		chk("in_bit_off", 32'h0000_0045, 32'(cfg.in_bit_off));
		chk("out_bit_off", 32'h0000_0123, 32'(cfg.out_bit_off));
		chk("in_ptr", 32'h8000_1234, cfg.in_ptr);
		chk("crc_en", 32'h0000_0000, 32'(cfg.crc_en));
		chk("scram_en", 32'h0000_0000, 32'(cfg.scram_en));
		chk("repeat_en", 32'h0000_0001, 32'(cfg.repeat_en));
		chk("chained", 32'h0000_0001, 32'(cfg.chained));
		chk("pfo", 32'h0000_0100, 32'(cfg.pfo));
		chk("pso", 32'h0000_0200, 32'(cfg.pso));
		chk("x_param", 32'h0000_0003, 32'(cfg.x_param));
		chk("sys_eini", 32'({1'b0, hw[3][14:0]}), 32'(cfg.sys_eini));
		chk("sys_em", 32'({1'b0, hw[3][30:16]}), 32'(cfg.sys_eminus));
		chk("p1_eini1", 32'(hw[4][15:0]), 32'(cfg.p1_eini1));
		chk("p2_eini1", 32'({1'b0, hw[4][30:16]}), 32'(cfg.p2_eini1));
		chk("p1_eini2", 32'(hw[5][15:0]), 32'(cfg.p1_eini2));
		chk("p2_eini2", 32'({1'b0, hw[5][30:16]}), 32'(cfg.p2_eini2));
		chk("p_em1", 32'(hw[6][15:0]), 32'(cfg.p_eminus1));
		chk("p2_em2", 32'({1'b0, hw[6][30:16]}), 32'(cfg.p2_eminus2));
		chk("p1_em2", 32'(hw[7][12:0]), 32'(cfg.p1_eminus2));
		rd(ujh_pkg::ADDR_STATUS, q);
		chk("embedded", 32'h0000_0001, 32'(q[5]));
		chk("last_err", 32'h0000_0000, 32'(q[4]));
	endtask : t_fields

	// Every collection code from the header area, then interlaced.
	task automatic t_coll;
		wr(ujh_pkg::ADDR_JOB, 32'h0000_0001);
		wr(ujh_pkg::ADDR_HBASE, 32'h0000_1000);
		h.crc_off = 1'b0;
		for (int t = 0; t < 5; t++)
		begin
			h.coll_sel = (t < 4);
			h.coll_type = 2'(t);
			wr(8'h60, h);
			run_job(1'b1);
			chk("interlace", 32'(t == 4), 32'(cfg.interlace));
			chk("par_off_en", 32'(t < 4), 32'(cfg.par_off_en));
			if (t < 4)
				chk("rows", 32'(2 * t), 32'(cfg.rows));
			q = (t > 0 && t < 4) ? 32'h0000_0003 : 32'h0000_0000;
			chk("phys_ch", q, 32'(cfg.phys_ch));
		end
		chk("in_bit_off", 32'h0000_0ACE, 32'(cfg.in_bit_off));
		chk("crc_en", 32'h0000_0001, 32'(cfg.crc_en));
		rd(ujh_pkg::ADDR_STATUS, q);
		chk("embedded", 32'h0000_0000, 32'(q[5]));
		// A zero channel count under the interleaver is flagged.
		h.coll_sel = 1'b1;
		h.coll_type = 2'b01;
		h.phys_ch = 4'h0;
		wr(8'h60, h);
		run_job(1'b1);
		rd(ujh_pkg::ADDR_STATUS, q);
		chk("phys_err", 32'h0000_0001, 32'(q[3]));
	endtask : t_coll

	// Block sizes on both sides of each limit.
	task automatic t_size;
		logic [12:0] s [4];
		s = '{13'h0027, 13'h0028, 13'h13FA, 13'h13FB};
		for (int i = 0; i < 4; i++)
		begin
			h.block_bits = s[i];
			wr(8'h60, h);
			run_job(i == 1 || i == 2);
			rd(ujh_pkg::ADDR_STATUS, q);
			chk("size_err", 32'(i == 0 || i == 3), 32'(q[2]));
		end
	endtask : t_size

	// Error arithmetic, continue versus reload, then an enhanced-channel
	// header whose stage-one parity matching is switched off.
	task automatic t_rm;
		h.block_bits = 13'h0064;
		h.rm_restart = 1'b1;
		wr(8'h60, h);
		wr(8'h6C, 32'h0002_0005);
		wr(ujh_pkg::ADDR_EPLUS, 32'h0000_0006);
		run_job(1'b1);
		steps(4, 4'b0100);
		rd(ujh_pkg::ADDR_RMERR, q);
		chk("rm_err", 32'h0000_0003, q);
		h.rm_restart = 1'b0;
		wr(8'h60, h);
		wr(8'h6C, 32'h0002_0064);
		run_job(1'b1);
		steps(1, 4'b0000);
		rd(ujh_pkg::ADDR_RMERR, q);
		chk("rm_err", 32'h0000_0001, q);
		h.rm_restart = 1'b1;
		wr(8'h60, h);
		run_job(1'b1);
		steps(1, 4'b0000);
		rd(ujh_pkg::ADDR_RMERR, q);
		chk("rm_err", 32'h0000_0062, q);
		wr(8'h78, 32'h1357_0000);
		wr(8'h70, 32'h0001_0001);
		run_job(1'b1);
		chk("p_em1", 32'h0000_0000, 32'(cfg.p_eminus1));
		chk("p1_eini1", 32'h0000_0001, 32'(cfg.p1_eini1));
		chk("p2_eini1", 32'h0000_0001, 32'(cfg.p2_eini1));
	endtask : t_rm

	// ----------------------------------------------------------------
	// Main sequence.
	// ----------------------------------------------------------------
	initial
	begin
		rst = 1'b1;
		rm_step = 1'b0;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		t_reset();
		t_fields();
		t_coll();
		t_size();
		t_rm();
		final_report();
	end

endmodule : umts_encoder_job_header_decode_tb

`default_nettype wire
